// ==== src/rst_seq_pkg.sv ====
// Package with the constants and state encoding of the reset sequencer.
package rst_seq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // Least low time of the reset pin during operation, in system clock states.
  localparam int RUN_HOLD_STATES = 20;
  // Least low time of the reset pin at power-up.
  localparam int POWERUP_HOLD_MS = 20;
  localparam int POWERUP_HOLD_CYCLES = (POWERUP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the low-time counter.
  localparam int HOLD_CNT_W = 5;

  // ----------------------------------------
  // Register reset values and field positions
  // ----------------------------------------
  localparam int EXT_CTRL_TRACE_BIT = 7;
  localparam int EXT_CTRL_MASK_LSB = 0;
  localparam int EXT_CTRL_MASK_W = 3;
  localparam int COND_CODE_MASK_BIT = 7;
  localparam logic [7:0] EXT_CTRL_INIT = 8'h87;
  localparam logic [7:0] COND_CODE_INIT = 8'h80;
  localparam logic [1:0] INTR_MODE0 = 2'h0;
  localparam logic [31:0] PC_INIT = 32'h0;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_INIT = 3'b001,
    ST_FETCH = 3'b010,
    ST_LOAD = 3'b011,
    ST_RUN = 3'b100
  } seq_state_type;

endpackage : rst_seq_pkg

// ==== src/sync_2ff.sv ====
// Two flip-flop synchroniser for one asynchronous level.
module sync_2ff #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // The first stage feeds only the second stage.
  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  // Both stages take the INIT value at reset.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage1 <= INIT;
      syncOut <= INIT;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule : sync_2ff

// ==== src/cpu_reset_sequencer.sv ====
// Reset sequencer that holds the CPU in reset and runs reset exception handling.
// Overview of operation
// R01: A pending reset overrides every other exception and interrupt request.
// R02: While the reset pin is low all activity stops and the block stays in reset.
// R03: Reset returns CPU state and module registers to their initial values.
// R04: Right after reset the interrupt control mode is mode 0.
// R05: A rising edge of the reset pin starts reset exception handling.
// R06: A watchdog overflow resets the device like the reset pin.
// R07: At power-up the outside source holds the pin low at least 20 ms.
// R08: During operation the outside source holds the pin low at least 20 states.
// R09: Handling first clears the trace bit and sets the interrupt mask bits in both registers.
// R10: Then the reset vector is fetched into the program counter and execution starts.
// R11: The pin is synchronised and its consecutive low states are counted.
module cpu_reset_sequencer #(
  parameter int ADDR_W = 32,
  parameter logic [ADDR_W-1:0] RESET_VECTOR_ADDR = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Reset sources
  input wire logic reset_pin_n,
  input wire logic wdtOverflow,
  // Exception requests from the rest of the chip
  input wire logic irqPending,
  // Vector fetch port
  output logic vecReq,
  output logic [ADDR_W-1:0] vecAddr,
  input wire logic vecAck,
  input wire logic [ADDR_W-1:0] vecData,
  // CPU state
  output logic cpuHalt,
  output logic moduleResetN,
  output logic cpuRun,
  output logic irqTaken,
  output logic [1:0] intrMode,
  output logic [7:0] extended_ctrl_reg,
  output logic [7:0] condition_code_reg,
  output logic [ADDR_W-1:0] programCounter,
  output logic holdTooShort
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic pinSync;
  logic pinPrev;
  logic next_pinPrev;

  // R11 sync pin
  sync_2ff #(.INIT(1'b0)) sync_2ff_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .asyncIn(reset_pin_n),
    .syncOut(pinSync)
  );

  // The watchdog is on the same clock, so it needs no synchroniser.
  logic resetReq;
  assign resetReq = !pinSync || wdtOverflow;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  rst_seq_pkg::seq_state_type state;
  rst_seq_pkg::seq_state_type next_state;
  logic [rst_seq_pkg::HOLD_CNT_W-1:0] lowCount;
  logic [rst_seq_pkg::HOLD_CNT_W-1:0] next_lowCount;
  logic wdtCause;
  logic next_wdtCause;
  logic next_vecReq;
  logic [ADDR_W-1:0] next_vecAddr;
  logic next_cpuHalt;
  logic next_moduleResetN;
  logic next_cpuRun;
  logic next_irqTaken;
  logic [1:0] next_intrMode;
  logic [7:0] next_extended_ctrl_reg;
  logic [7:0] next_condition_code_reg;
  logic [ADDR_W-1:0] next_pc;
  logic next_holdTooShort;

  // ----------------------------------------
  // Derived constants
  // ----------------------------------------
  // The saturation point of the low counter doubles as the pass mark for a long enough pulse.
  localparam logic [rst_seq_pkg::HOLD_CNT_W-1:0] HOLD_MIN = rst_seq_pkg::HOLD_CNT_W'(rst_seq_pkg::RUN_HOLD_STATES);
  // Program counter value before the vector arrives, cut to the address width.
  localparam logic [ADDR_W-1:0] PC_INIT_W = ADDR_W'(rst_seq_pkg::PC_INIT);
  // Mask field of the extended control register with every bit set.
  localparam logic [rst_seq_pkg::EXT_CTRL_MASK_W-1:0] MASK_ALL = '1;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Next-state logic of the whole sequence; the reset request is tested first so nothing else can win.
  always_comb begin
    next_state = state;
    next_lowCount = lowCount;
    next_wdtCause = wdtCause;
    next_pinPrev = pinSync;
    next_vecReq = 1'b0;
    next_vecAddr = vecAddr;
    next_cpuHalt = cpuHalt;
    next_moduleResetN = moduleResetN;
    next_cpuRun = cpuRun;
    next_irqTaken = 1'b0;
    next_intrMode = intrMode;
    next_extended_ctrl_reg = extended_ctrl_reg;
    next_condition_code_reg = condition_code_reg;
    next_pc = programCounter;
    next_holdTooShort = holdTooShort;
    // R01 reset wins
    // R02 halt on low
    // R06 watchdog reset
    if (resetReq) begin
      next_state = rst_seq_pkg::ST_RESET;
      next_cpuHalt = 1'b1;
      next_cpuRun = 1'b0;
      // R03 modules held
      next_moduleResetN = 1'b0;
      // R04 mode zero
      next_intrMode = rst_seq_pkg::INTR_MODE0;
      if (wdtOverflow) begin
        next_wdtCause = 1'b1;
      end
      // R11 count lows
      if (!pinSync && lowCount != HOLD_MIN) begin
        next_lowCount = lowCount + 1'b1;
      end
    end else begin
      case (state)
        rst_seq_pkg::ST_RESET: begin
          // R05 rising edge
          if ((pinSync && !pinPrev) || wdtCause) begin
            // R08 flag a short pulse; the sequence still runs.
            next_holdTooShort = !wdtCause && (lowCount != HOLD_MIN);
            next_state = rst_seq_pkg::ST_INIT;
          end
        end
        rst_seq_pkg::ST_INIT: begin
          // R03 initial values
          next_moduleResetN = 1'b1;
          next_lowCount = '0;
          next_wdtCause = 1'b0;
          next_pc = PC_INIT_W;
          // R09 trace clear mask set
          next_extended_ctrl_reg = rst_seq_pkg::EXT_CTRL_INIT;
          next_extended_ctrl_reg[rst_seq_pkg::EXT_CTRL_TRACE_BIT] = 1'b0;
          next_extended_ctrl_reg[rst_seq_pkg::EXT_CTRL_MASK_LSB +: rst_seq_pkg::EXT_CTRL_MASK_W] = MASK_ALL;
          next_condition_code_reg = rst_seq_pkg::COND_CODE_INIT;
          next_condition_code_reg[rst_seq_pkg::COND_CODE_MASK_BIT] = 1'b1;
          next_state = rst_seq_pkg::ST_FETCH;
        end
        rst_seq_pkg::ST_FETCH: begin
          // R10 fetch vector
          next_vecReq = 1'b1;
          next_vecAddr = RESET_VECTOR_ADDR;
          next_state = rst_seq_pkg::ST_LOAD;
        end
        rst_seq_pkg::ST_LOAD: begin
          next_vecReq = !vecAck;
          if (vecAck) begin
            // R10 load program counter
            next_pc = vecData;
            next_cpuHalt = 1'b0;
            next_cpuRun = 1'b1;
            next_state = rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_RUN: begin
          // Interrupts are only served once the CPU runs.
          next_irqTaken = irqPending;
        end
        default: begin
          next_state = rst_seq_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register stage
  // ----------------------------------------
  // Register stage; every output comes straight from here.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= rst_seq_pkg::ST_RESET;
      lowCount <= '0;
      wdtCause <= 1'b0;
      pinPrev <= 1'b0;
      vecReq <= 1'b0;
      vecAddr <= '0;
      cpuHalt <= 1'b1;
      moduleResetN <= 1'b0;
      cpuRun <= 1'b0;
      irqTaken <= 1'b0;
      intrMode <= rst_seq_pkg::INTR_MODE0;
      extended_ctrl_reg <= rst_seq_pkg::EXT_CTRL_INIT;
      condition_code_reg <= rst_seq_pkg::COND_CODE_INIT;
      programCounter <= '0;
      holdTooShort <= 1'b0;
    end else begin
      state <= next_state;
      lowCount <= next_lowCount;
      wdtCause <= next_wdtCause;
      pinPrev <= next_pinPrev;
      vecReq <= next_vecReq;
      vecAddr <= next_vecAddr;
      cpuHalt <= next_cpuHalt;
      moduleResetN <= next_moduleResetN;
      cpuRun <= next_cpuRun;
      irqTaken <= next_irqTaken;
      intrMode <= next_intrMode;
      extended_ctrl_reg <= next_extended_ctrl_reg;
      condition_code_reg <= next_condition_code_reg;
      programCounter <= next_pc;
      holdTooShort <= next_holdTooShort;
    end
  end

endmodule : cpu_reset_sequencer

// ==== tb/cpu_reset_sequencer_asserts.sv ====
// Checker of the port relations of the reset sequencer.
module cpu_reset_sequencer_asserts #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Sources and requests
  input wire logic reset_pin_n,
  input wire logic wdtOverflow,
  input wire logic vecAck,
  input wire logic [ADDR_W-1:0] vecData,
  // Sequencer outputs
  input wire logic vecReq,
  input wire logic cpuHalt,
  input wire logic moduleResetN,
  input wire logic cpuRun,
  input wire logic irqTaken,
  input wire logic [1:0] intrMode,
  input wire logic [7:0] extended_ctrl_reg,
  input wire logic [7:0] condition_code_reg,
  input wire logic [ADDR_W-1:0] programCounter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Two sync flops plus the state register set the halt latency.
  property p_halt; $fell(reset_pin_n) |-> ##[1:4] (cpuHalt && !moduleResetN); endproperty
  a_halt: assert property (p_halt) else $error("halt late");
  property p_hold; !reset_pin_n [*5] |-> cpuHalt && !cpuRun; endproperty
  a_hold: assert property (p_hold) else $error("ran in reset");
  property p_irq; cpuHalt && $past(cpuHalt) |-> !irqTaken; endproperty
  a_irq: assert property (p_irq) else $error("irq in reset");
  property p_mode; !moduleResetN |-> intrMode == 2'h0; endproperty
  a_mode: assert property (p_mode) else $error("mode not 0");
  property p_init; $rose(moduleResetN) |-> !extended_ctrl_reg[7] && &extended_ctrl_reg[2:0] && condition_code_reg[7];
  endproperty
  a_init: assert property (p_init) else $error("bad init");
  property p_wdt; wdtOverflow |-> ##[1:2] cpuHalt; endproperty
  a_wdt: assert property (p_wdt) else $error("wdt ignored");
  property p_start; $rose(reset_pin_n) |-> ##[1:8] vecReq; endproperty
  a_start: assert property (p_start) else $error("no fetch");
  property p_pc; vecReq && vecAck |=> programCounter == $past(vecData) && cpuRun; endproperty
  a_pc: assert property (p_pc) else $error("bad pc");
  c_run: cover property ($rose(cpuRun));
  c_wdt: cover property (wdtOverflow);
  c_irq: cover property (irqTaken);
endmodule : cpu_reset_sequencer_asserts
bind cpu_reset_sequencer cpu_reset_sequencer_asserts #(.ADDR_W(ADDR_W)) cpu_reset_sequencer_asserts_inst (.*);

// ==== tb/reset_source_model.sv ====
// Model of the reset source and of the vector memory.
module reset_source_model #(
  parameter int PWRUP = 64
) (
  // Clock and fetch request
  input wire logic sys_clk,
  input wire logic vecReq,
  input wire logic [3:0] ackDly,
  // Pin and fetch answer
  output logic reset_pin_n,
  output logic vecAck,
  output logic [31:0] vecData
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // power-up hold, shortened to PWRUP cycles to keep the run brief.
  initial begin
    reset_pin_n = 1'b0;
    vecAck = 1'b0;
    repeat (PWRUP) @(negedge sys_clk);
    reset_pin_n = 1'b1;
  end
  // running hold; short lengths are asked for on purpose.
  task automatic pulse(input int len);
    @(negedge sys_clk);
    reset_pin_n = 1'b0;
    repeat (len) @(negedge sys_clk);
    reset_pin_n = 1'b1;
  endtask : pulse
  // Off the ack the data is inverted, so a stale vector never passes.
  assign vecData = vecAck ? 32'h00001F40 : 32'hFFFFE0BF;
  always @(negedge sys_clk) begin
    if (vecReq && !vecAck) begin
      n <= (n == ackDly) ? 0 : n + 1;
      vecAck <= (n == ackDly);
    end else begin
      // A fetch cut short by a new reset must not leave its delay count behind.
      n <= 0;
      vecAck <= 1'b0;
    end
  end
endmodule : reset_source_model

// ==== tb/tb_cpu_reset_sequencer.sv ====
// Self-checking bench of the reset sequencer.
module tb_cpu_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, wdtOverflow = 1'b0, irqPending = 1'b0;
  logic [3:0] ackDly = 4'h0;
  logic reset_pin_n, vecReq, vecAck, cpuHalt, moduleResetN, cpuRun, irqTaken, holdTooShort;
  logic [1:0] intrMode;
  logic [7:0] extended_ctrl_reg, condition_code_reg;
  logic [31:0] vecAddr, vecData, programCounter;
  int failures = 0, comparisons = 0, cycles = 0;
  always #2 sys_clk = ~sys_clk;
  // A vector address other than zero, so a stuck address output shows.
  localparam logic [31:0] VEC_ADDR = 32'h00000100;
  cpu_reset_sequencer #(
    .ADDR_W(32),
    .RESET_VECTOR_ADDR(VEC_ADDR)
  ) cpu_reset_sequencer_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reset_pin_n(reset_pin_n),
    .wdtOverflow(wdtOverflow),
    .irqPending(irqPending),
    .vecReq(vecReq),
    .vecAddr(vecAddr),
    .vecAck(vecAck),
    .vecData(vecData),
    .cpuHalt(cpuHalt),
    .moduleResetN(moduleResetN),
    .cpuRun(cpuRun),
    .irqTaken(irqTaken),
    .intrMode(intrMode),
    .extended_ctrl_reg(extended_ctrl_reg),
    .condition_code_reg(condition_code_reg),
    .programCounter(programCounter),
    .holdTooShort(holdTooShort)
  );
  reset_source_model reset_source_model_inst (
    .sys_clk(sys_clk),
    .vecReq(vecReq),
    .ackDly(ackDly),
    .reset_pin_n(reset_pin_n),
    .vecAck(vecAck),
    .vecData(vecData)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // A hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic wait_run();
    int i;
    // The power-up hold alone lasts some sixty cycles, so the limit leaves room for it and the fetch.
    for (i = 0; i < 200 && cpuRun !== 1'b1; i++) @(negedge sys_clk);
    chk(cpuRun, 32'h1);
    chk(programCounter, 32'h1F40);
    chk(vecAddr, VEC_ADDR);
    chk(vecReq, 32'h0);
  endtask : wait_run
  task automatic t_boot();
    wait_run();
    chk(extended_ctrl_reg, 32'h07);
    chk(condition_code_reg, 32'h80);
    chk(intrMode, 32'h0);
  endtask : t_boot
  task automatic t_pin();
    @(negedge sys_clk);
    irqPending = 1'b1;
    @(negedge sys_clk);
    chk(irqTaken, 32'h1);
    ackDly = 4'h5;
    fork
      reset_source_model_inst.pulse(20);
      begin
        repeat (6) @(negedge sys_clk);
        chk(irqTaken, 32'h0);
        chk(cpuHalt, 32'h1);
        chk(moduleResetN, 32'h0);
      end
    join
    irqPending = 1'b0;
    wait_run();
    chk(holdTooShort, 32'h0);
  endtask : t_pin
  task automatic t_short();
    ackDly = 4'h0;
    reset_source_model_inst.pulse(5);
    chk(cpuHalt, 32'h1);
    wait_run();
    chk(holdTooShort, 32'h1);
  endtask : t_short
  task automatic t_wdt();
    @(negedge sys_clk);
    wdtOverflow = 1'b1;
    repeat (2) @(negedge sys_clk);
    wdtOverflow = 1'b0;
    chk(cpuHalt, 32'h1);
    wait_run();
  endtask : t_wdt
  initial begin
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    t_boot();
    t_pin();
    t_short();
    t_wdt();
    print_verdict();
  end
endmodule : tb_cpu_reset_sequencer
